// File: shared/tbsc_pkg.sv
// Constants, carriers and helpers for the 10BASE-T status and control register block
// Behaviour
// - Bit 15 ignores writes and always reads back as zero.
// - Three-bit squelch field at bits 11:9, reset 100, sets squelch-on threshold.
// - Wrap-off bit 8 is ORed with the basic mode control loopback bit.
// - Wrap-off one disables 10 Mb loopback; zero, the reset value, keeps it.
// - Bit 7 stops link pulses; ORed with the host link override input.
// - Bit 6 or host override reports good 10 Mb link, else normal status.
// - Bit 5 set forces inverted receive polarity; clear leaves normal handling.
// - Polarity status bit 4 latches high, mirrored in transceiver state bit 12.
// - Polarity status reads one for inverted polarity, zero for correct polarity.
// - Bit 3 set turns automatic polarity correction off; the polarity status bit still latches.
// - Bit 2, reset one, is silence scale MSB beside signal detect bit 10.
// - Bit 1 turns the heartbeat off, only in half-duplex 10 Mb.
// - At 100 Mb or full duplex the heartbeat is always off.
// - Bit 0 turns the jabber guard off, in 10 Mb operation only.
package tbsc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] TBSC_IDX = 8'h1A;
	localparam logic [7:0] PHYST_IDX = 8'h10;

	localparam logic [15:0] TBSC_RST = 16'h0804;
	localparam logic [15:0] TBSC_WMASK = 16'h7FEF;

	localparam int SQ_HI = 11;
	localparam int SQ_LO = 9;
	localparam int WRAP_POS = 8;
	localparam int NLP_POS = 7;
	localparam int FLINK_POS = 6;
	localparam int FPOL_POS = 5;
	localparam int POL_POS = 4;
	localparam int APOL_POS = 3;
	localparam int SCALE_POS = 2;
	localparam int SQE_POS = 1;
	localparam int JAB_POS = 0;
	localparam int PHYST_POL_POS = 12;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} tbsc_axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tbsc_axil_rsp_s;

	typedef struct packed {
		logic wr_en;
		logic [7:0] waddr;
		logic [15:0] wdata;
		logic [1:0] wbe;
		logic rd_en;
		logic [7:0] raddr;
	} tbsc_lbus_s;

	typedef struct packed {
		logic [2:0] squelch;
		logic ten_mb_wrap_off;
		logic link_pulse_tx_off;
		logic link_good_10;
		logic rx_pol_invert;
		logic auto_pair_correct_off;
		logic [1:0] silence_scale;
		logic sqe_test_off;
		logic long_tx_guard_off;
	} tbsc_ctrl_s;

	localparam tbsc_ctrl_s CTRL_RST = '{squelch: 3'h4, silence_scale: 2'h2, default: '0};

	function automatic logic [7:0] reg_byte(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction : reg_byte

endpackage : tbsc_pkg

// File: tb/tbsc_reg_top_tb_top.sv
// Self-checking bench for the 10BASE-T status and control register block
module tbsc_reg_top_tb_top import tbsc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk;
	logic nrst;
	tbsc_axil_req_s req;
	tbsc_axil_rsp_s rsp;
	tbsc_ctrl_s ctrl;
	// Side inputs: loopback, override, raw link, pol, scale lo, 100 Mb, full duplex
	logic [6:0] side;
	logic [15:0] shadow;
	logic [31:0] rd;
	logic [1:0] rs;
	int bad_count;
	int checks;

	tbsc_reg_top dut
	(
		.core_clk_in(clk),
		.nrst_in(nrst),
		.axi_req_in(req),
		.axi_rsp_out(rsp),
		.basic_loopback_in(side[0]),
		.host_link_override_in(side[1]),
		.link_10_raw_in(side[2]),
		.rx_pol_inverted_in(side[3]),
		.sd_scale_lo_in(side[4]),
		.speed_100_in(side[5]),
		.full_duplex_in(side[6]),
		.ctrl_out(ctrl)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
			bad_count++;
		end
	endtask : chk

	task automatic hang();
		$display("MISMATCH %0t bus timeout", $time);
		bad_count++;
		end_sim();
	endtask : hang

	// Address and data offered together; bready and rready stay high throughout
	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r,
		input logic [3:0] s = 4'hF);
		int n;
		req.awaddr <= a;
		req.wdata <= {16'h0000, d};
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end
		while (!rsp.bvalid && n < 40);
		r = rsp.bresp;
		if (n >= 40) hang();
		// Spare edge so a following request never reassigns valid in this step
		@(posedge clk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end
		while (!rsp.rvalid && n < 40);
		d = rsp.rdata;
		r = rsp.rresp;
		if (n >= 40) hang();
		@(posedge clk);
	endtask : axi_rd

	task automatic wr_chk(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er,
		input logic [3:0] s = 4'hF);
		axi_wr(a, d, rs, s);
		chk({30'h0, rs}, {30'h0, er}, "write response");
	endtask : wr_chk

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
		input string m);
		axi_rd(a, rd, rs);
		chk(rd, ed, m);
		chk({30'h0, rs}, {30'h0, er}, "read response");
	endtask : rd_chk

	function automatic tbsc_ctrl_s ex(input logic [15:0] r, input logic [6:0] s);
		tbsc_ctrl_s e;
		e.squelch = r[11:9];
		e.ten_mb_wrap_off = r[8] | s[0];
		e.link_pulse_tx_off = r[7] | s[1];
		e.link_good_10 = r[6] | s[1] | s[2];
		e.rx_pol_invert = r[5] | (~r[3] & s[3]);
		e.auto_pair_correct_off = r[3];
		e.silence_scale = {r[2], s[4]};
		e.sqe_test_off = r[1] | s[5] | s[6];
		e.long_tx_guard_off = r[0] & ~s[5];
		return e;
	endfunction : ex

	task automatic pulse();
		side[3] <= 1'b1;
		@(posedge clk);
		side[3] <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : pulse

	task automatic t_reset();
		side <= '0;
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'(ctrl), 32'(ex(16'h0804, 7'h00)), "ctrl after reset");
		rd_chk(8'h68, 32'h0000_0804, RESP_OKAY, "reset value");
		shadow = 16'h0804;
	endtask : t_reset

	// Every side input combination against four register patterns
	task automatic t_side();
		logic [15:0] vals [4];
		vals = '{16'hFFFF, 16'h0000, 16'h2AAA, 16'h5555};
		for (int v = 0; v < 4; v++)
		begin
			wr_chk(8'h68, vals[v], RESP_OKAY);
			rd_chk(8'h68, {16'h0, vals[v] & 16'h7FEF}, RESP_OKAY, "readback");
			for (int i = 0; i < 128; i++)
			begin
				side <= i[6:0];
				repeat (2) @(posedge clk);
				chk(32'(ctrl), 32'(ex(vals[v], i[6:0])), "derived ctrl");
			end
			// Detector pulses above set the latch; clear it before the next readback
			side <= '0;
			@(posedge clk);
			axi_rd(8'h40, rd, rs);
		end
		shadow = 16'h5545;
	endtask : t_side

	task automatic t_pol();
		pulse();
		rd_chk(8'h40, 32'h0000_1000, RESP_OKAY, "mirror set");
		rd_chk(8'h68, {16'h0, shadow}, RESP_OKAY, "cleared by mirror read");
		pulse();
		wr_chk(8'h68, 16'h5545, RESP_OKAY);
		wr_chk(8'h40, 16'hFFFF, RESP_OKAY);
		rd_chk(8'h68, 32'h0000_5555, RESP_OKAY, "latched status");
		rd_chk(8'h40, 32'h0000_0000, RESP_OKAY, "cleared by ctrl read");
	endtask : t_pol

	// Byte lanes: strobe 0 covers bits 7:0, strobe 1 bits 15:8, upper strobes do nothing
	task automatic t_lanes();
		wr_chk(8'h68, 16'hFFFF, RESP_OKAY, 4'h1);
		rd_chk(8'h68, 32'h0000_55EF, RESP_OKAY, "low lane write");
		wr_chk(8'h68, 16'h0000, RESP_OKAY, 4'h2);
		rd_chk(8'h68, 32'h0000_00EF, RESP_OKAY, "high lane write");
		wr_chk(8'h68, 16'h1234, RESP_OKAY, 4'hC);
		rd_chk(8'h68, 32'h0000_00EF, RESP_OKAY, "upper strobes ignored");
		shadow = 16'h00EF;
	endtask : t_lanes

	task automatic t_err();
		wr_chk(8'h6C, 16'h0000, RESP_SLVERR);
		rd_chk(8'h6C, 32'h0000_0000, RESP_SLVERR, "unmapped read");
		wr_chk(8'h69, 16'h0000, RESP_SLVERR);
		rd_chk(8'h68, {16'h0, shadow}, RESP_OKAY, "refused write kept out");
		pulse();
	endtask : t_err

	initial
	begin
		bad_count = 0;
		checks = 0;
		nrst = 1'b0;
		side = '0;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		t_reset();
		t_side();
		t_pol();
		t_lanes();
		t_err();
		// Second hard reset with the latch set and fields altered
		t_reset();
		end_sim();
	end

endmodule : tbsc_reg_top_tb_top

// File: verilog/tbsc_axil_slv.sv
// AXI4-Lite slave front end turning bus transfers into local strobes
module tbsc_axil_slv
	import tbsc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire tbsc_axil_req_s axi_req_in,
	output tbsc_axil_rsp_s axi_rsp_out,
	output tbsc_lbus_s lbus_out,
	input wire logic wr_ok_in,
	input wire logic rd_ok_in,
	input wire logic [15:0] rd_data_in
);

	logic aw_have_ff;
	logic w_have_ff;
	logic bvalid_ff;
	logic rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [15:0] wdata_ff;
	logic [1:0] wbe_ff;
	logic [1:0] bresp_ff;
	logic [1:0] rresp_ff;
	logic [15:0] rdata_ff;

	// No new address or data while a response waits, so at most one write in flight
	wire logic aw_rdy = !aw_have_ff && !bvalid_ff;
	wire logic w_rdy = !w_have_ff && !bvalid_ff;
	wire logic aw_take = axi_req_in.awvalid && aw_rdy;
	wire logic w_take = axi_req_in.wvalid && w_rdy;
	wire logic aw_got = aw_have_ff || aw_take;
	wire logic w_got = w_have_ff || w_take;
	wire logic wr_fire = aw_got && w_got;
	wire logic ar_rdy = !rvalid_ff;
	wire logic rd_fire = axi_req_in.arvalid && ar_rdy;

	wire logic [7:0] cur_waddr = aw_have_ff ? awaddr_ff : axi_req_in.awaddr;
	wire logic [15:0] cur_wdata = w_have_ff ? wdata_ff : axi_req_in.wdata[15:0];
	wire logic [1:0] cur_wbe = w_have_ff ? wbe_ff : axi_req_in.wstrb[1:0];

	assign lbus_out = '{wr_en: wr_fire, waddr: cur_waddr, wdata: cur_wdata, wbe: cur_wbe,
		rd_en: rd_fire, raddr: axi_req_in.araddr};

	assign axi_rsp_out = '{awready: aw_rdy, wready: w_rdy, bvalid: bvalid_ff, bresp: bresp_ff,
		arready: ar_rdy, rvalid: rvalid_ff, rdata: {16'h0000, rdata_ff}, rresp: rresp_ff};

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 16'h0000;
			wbe_ff <= 2'h0;
		end
		else
		begin
			aw_have_ff <= aw_got && !wr_fire;
			w_have_ff <= w_got && !wr_fire;
			awaddr_ff <= aw_take ? axi_req_in.awaddr : awaddr_ff;
			wdata_ff <= w_take ? axi_req_in.wdata[15:0] : wdata_ff;
			wbe_ff <= w_take ? axi_req_in.wstrb[1:0] : wbe_ff;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 16'h0000;
		end
		else
		begin
			bvalid_ff <= wr_fire || (bvalid_ff && !axi_req_in.bready);
			bresp_ff <= wr_fire ? (wr_ok_in ? RESP_OKAY : RESP_SLVERR) : bresp_ff;
			rvalid_ff <= rd_fire || (rvalid_ff && !axi_req_in.rready);
			rresp_ff <= rd_fire ? (rd_ok_in ? RESP_OKAY : RESP_SLVERR) : rresp_ff;
			rdata_ff <= rd_fire ? rd_data_in : rdata_ff;
		end
	end

endmodule : tbsc_axil_slv

// File: verilog/tbsc_reg_top.sv
// 10BASE-T status and control register with its derived control outputs
module tbsc_reg_top
	import tbsc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire tbsc_axil_req_s axi_req_in,
	output tbsc_axil_rsp_s axi_rsp_out,
	input wire logic basic_loopback_in,
	input wire logic host_link_override_in,
	input wire logic link_10_raw_in,
	input wire logic rx_pol_inverted_in,
	input wire logic sd_scale_lo_in,
	input wire logic speed_100_in,
	input wire logic full_duplex_in,
	output tbsc_ctrl_s ctrl_out
);

	tbsc_lbus_s lbus;
	logic [15:0] ctl_ff;
	logic pol_latch_ff;
	tbsc_ctrl_s ctrl_ff;
	logic wr_ok;
	logic rd_ok;
	logic [15:0] rd_data;

	tbsc_axil_slv u_slv
	(
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.axi_req_in(axi_req_in),
		.axi_rsp_out(axi_rsp_out),
		.lbus_out(lbus),
		.wr_ok_in(wr_ok),
		.rd_ok_in(rd_ok),
		.rd_data_in(rd_data)
	);

	// Address decode; misaligned addresses miss and answer with an error
	wire logic hit_tb_wr = lbus.wr_en && (lbus.waddr == reg_byte(TBSC_IDX));
	wire logic hit_ps_wr = lbus.wr_en && (lbus.waddr == reg_byte(PHYST_IDX));
	wire logic hit_tb_rd = lbus.rd_en && (lbus.raddr == reg_byte(TBSC_IDX));
	wire logic hit_ps_rd = lbus.rd_en && (lbus.raddr == reg_byte(PHYST_IDX));

	assign wr_ok = hit_tb_wr || hit_ps_wr;
	assign rd_ok = hit_tb_rd || hit_ps_rd;

	// Byte lanes; the mask keeps bit 15 and the polarity status out of reach
	wire logic [15:0] lane_mask = {{8{lbus.wbe[1]}}, {8{lbus.wbe[0]}}};
	wire logic [15:0] wr_mask = lane_mask & TBSC_WMASK;
	wire logic [15:0] nxt_ctl = hit_tb_wr ? ((ctl_ff & ~wr_mask) | (lbus.wdata & wr_mask))
		: ctl_ff;

	// Detection wins over a read that clears in the same cycle
	wire logic pol_clear = hit_tb_rd || hit_ps_rd;
	wire logic nxt_pol_latch = rx_pol_inverted_in || (pol_latch_ff && !pol_clear);

	wire logic [15:0] view_tb = ctl_ff | ({15'h0000, pol_latch_ff} << POL_POS);
	wire logic [15:0] view_ps = {15'h0000, pol_latch_ff} << PHYST_POL_POS;

	assign rd_data = hit_tb_rd ? view_tb : (hit_ps_rd ? view_ps : 16'h0000);

	// Derived controls
	wire logic nxt_wrap_off = ctl_ff[WRAP_POS] || basic_loopback_in;
	wire logic nxt_nlp_off = ctl_ff[NLP_POS] || host_link_override_in;
	wire logic force_good = ctl_ff[FLINK_POS] || host_link_override_in;
	wire logic nxt_link_good = force_good || link_10_raw_in;
	wire logic auto_pol_off = ctl_ff[APOL_POS];
	// Automatic correction follows the detector only while enabled
	wire logic nxt_rx_inv = ctl_ff[FPOL_POS] || (!auto_pol_off && rx_pol_inverted_in);
	wire logic [1:0] nxt_scale = {ctl_ff[SCALE_POS], sd_scale_lo_in};
	// Heartbeat only lives in half-duplex 10 Mb
	wire logic nxt_sqe_off = ctl_ff[SQE_POS] || speed_100_in || full_duplex_in;
	// Guard control has no effect outside 10 Mb
	wire logic nxt_jab_off = ctl_ff[JAB_POS] && !speed_100_in;

	wire tbsc_ctrl_s nxt_ctrl = '{
		squelch: ctl_ff[SQ_HI:SQ_LO],
		ten_mb_wrap_off: nxt_wrap_off,
		link_pulse_tx_off: nxt_nlp_off,
		link_good_10: nxt_link_good,
		rx_pol_invert: nxt_rx_inv,
		auto_pair_correct_off: auto_pol_off,
		silence_scale: nxt_scale,
		sqe_test_off: nxt_sqe_off,
		long_tx_guard_off: nxt_jab_off
	};

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctl_ff <= TBSC_RST;
			pol_latch_ff <= 1'b0;
			ctrl_ff <= CTRL_RST;
		end
		else
		begin
			ctl_ff <= nxt_ctl;
			pol_latch_ff <= nxt_pol_latch;
			ctrl_ff <= nxt_ctrl;
		end
	end

	assign ctrl_out = ctrl_ff;

	a_top_bit_zero: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		hit_tb_wr && lbus.wdata[15]
		|=> (view_tb[15] == 1'b0) && (rd_data[15] == 1'b0)
	) else
		$error("bit 15 of the control register became set");

	a_squelch_track: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		hit_tb_wr && lbus.wbe[1]
		|=> ##1 ctrl_out.squelch == $past(lbus.wdata[SQ_HI:SQ_LO], 2)
	) else
		$error("squelch output does not follow the written field");

	a_wrap_or: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		(ctl_ff[WRAP_POS] || basic_loopback_in)
		|=> ctrl_out.ten_mb_wrap_off
	) else
		$error("loopback disable missing although a source is set");

	a_wrap_clear: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		!ctl_ff[WRAP_POS] && !basic_loopback_in
		|=> !ctrl_out.ten_mb_wrap_off
	) else
		$error("loopback disabled with both sources clear");

	a_nlp_or: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		##1 ctrl_out.link_pulse_tx_off == $past(ctl_ff[NLP_POS] || host_link_override_in)
	) else
		$error("link pulse disable is not the OR of its sources");

	a_link_force: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		(ctl_ff[FLINK_POS] || host_link_override_in) |=> ctrl_out.link_good_10
	) else
		$error("forced link not reported as good");

	a_link_normal: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		!ctl_ff[FLINK_POS] && !host_link_override_in
		|=> ctrl_out.link_good_10 == $past(link_10_raw_in)
	) else
		$error("unforced link status differs from the raw status");

	a_pol_force: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		ctl_ff[FPOL_POS] |=> ctrl_out.rx_pol_invert
	) else
		$error("forced inversion not applied");

	a_pol_latch: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		rx_pol_inverted_in |=> pol_latch_ff ##0 view_ps[PHYST_POL_POS]
	) else
		$error("inverted polarity not latched");

	a_pol_clear: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		(hit_tb_rd || hit_ps_rd) && !rx_pol_inverted_in
		|=> !pol_latch_ff
	) else
		$error("polarity status survived a read");

	a_pol_mirror: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		view_tb[POL_POS] == view_ps[PHYST_POL_POS]
	) else
		$error("polarity copies disagree");

	a_auto_pol_off: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		ctl_ff[APOL_POS] && !ctl_ff[FPOL_POS]
		|=> !ctrl_out.rx_pol_invert && ctrl_out.auto_pair_correct_off
	) else
		$error("polarity correction active while disabled");

	a_scale_hi: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		##1 ctrl_out.silence_scale == $past({ctl_ff[SCALE_POS], sd_scale_lo_in})
	) else
		$error("silence scale does not combine its two bits");

	a_sqe_half10: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		!speed_100_in && !full_duplex_in
		|=> ctrl_out.sqe_test_off == $past(ctl_ff[SQE_POS])
	) else
		$error("heartbeat control ignored in half-duplex 10 Mb");

	a_sqe_forced: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		(speed_100_in || full_duplex_in) |=> ctrl_out.sqe_test_off
	) else
		$error("heartbeat left on at 100 Mb or full duplex");

	a_jab_10_only: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		speed_100_in |=> !ctrl_out.long_tx_guard_off
	) else
		$error("jabber disable leaked into 100 Mb operation");

	a_jab_apply: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		ctl_ff[JAB_POS] && !speed_100_in |=> ctrl_out.long_tx_guard_off
	) else
		$error("jabber disable not applied at 10 Mb");

	a_ro_status: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		!rx_pol_inverted_in |=> !$rose(pol_latch_ff)
	) else
		$error("polarity status set without detection");

	a_ro_ctl_bit: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		hit_tb_wr |=> (ctl_ff[POL_POS] == 1'b0) && (ctl_ff[15] == 1'b0)
	) else
		$error("read-only bit stored by a write");

	a_ctl_stable: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		!hit_tb_wr |=> $stable(ctl_ff)
	) else
		$error("control register changed without a write");

	a_bresp_hold: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		axi_rsp_out.bvalid && !axi_req_in.bready
		|=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp)
	) else
		$error("write response dropped before it was taken");

	a_rdata_hold: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		axi_rsp_out.rvalid && !axi_req_in.rready
		|=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata)
	) else
		$error("read data changed before it was taken");

	a_read_answer: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		lbus.rd_en
		|=> axi_rsp_out.rvalid && axi_rsp_out.rresp == $past(rd_ok ? RESP_OKAY : RESP_SLVERR)
	) else
		$error("read not answered on the next cycle");

	a_write_answer: assert property (
		@(posedge core_clk_in) disable iff (!nrst_in)
		lbus.wr_en |=> axi_rsp_out.bvalid
	) else
		$error("write not answered on the next cycle");

endmodule : tbsc_reg_top

// File: verilog/tbsc_reg_top_fix.sv
// Spare design file; deliberately holds no module
